/* File: verilog/acw_pkg.sv */
// Purpose: Shared constants and types for the converter control block
// Assumes: Registers are byte wide, one per aligned 32-bit APB word
// Notes:   Byte address of a register is four times its index
`default_nettype none
package acw_pkg;
  // Register indices
  localparam logic [5:0] IDX_RUN  = 6'h00;
  localparam logic [5:0] IDX_WIN  = 6'h04;
  localparam logic [5:0] IDX_SAMP = 6'h05;
  localparam logic [5:0] IDX_POS  = 6'h08;
  localparam logic [5:0] IDX_NEG  = 6'h09;
  localparam logic [5:0] IDX_CMD  = 6'h0a;
  localparam logic [5:0] IDX_EV   = 6'h0b;
  localparam logic [5:0] IDX_IEN  = 6'h0c;
  localparam logic [5:0] IDX_IFL  = 6'h0d;
  localparam logic [5:0] IDX_HALT = 6'h0e;
  localparam logic [5:0] IDX_TMP  = 6'h0f;
  localparam logic [5:0] IDX_RESL = 6'h10;
  localparam logic [5:0] IDX_RESH = 6'h11;
  localparam logic [5:0] IDX_LTL  = 6'h12;
  localparam logic [5:0] IDX_LTH  = 6'h13;
  localparam logic [5:0] IDX_HTL  = 6'h14;
  localparam logic [5:0] IDX_HTH  = 6'h15;
  // Field positions
  localparam int BIT_START   = 0;
  localparam int BIT_STOP    = 1;
  localparam int BIT_RDY     = 0;
  localparam int BIT_WIN     = 1;
  localparam int BIT_CONTINUOUS_MODE = 1;
  localparam int BIT_EVEN    = 0;
  localparam int BIT_HALTRUN = 0;
  // Input selector codes
  localparam logic [6:0] POS_PIN_MAX  = 7'h15;
  localparam logic [6:0] NEG_PIN_MAX  = 7'h0f;
  localparam logic [6:0] SEL_GND      = 7'h40;
  localparam logic [6:0] POS_THERMAL  = 7'h42;
  localparam logic [6:0] POS_SUPPLY   = 7'h44;
  localparam logic [6:0] POS_SUPPLY2  = 7'h45;
  localparam logic [6:0] SEL_DAC      = 7'h48;
  localparam logic [6:0] POS_REF_LAST = 7'h4b;
  // Timing: default sample length and pclk cycles per converter clock
  localparam logic [9:0] SAMPLE_BASE = 10'h002;
  localparam logic [9:0] DIV_CYCLES  = 10'h002;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Window comparator modes
  typedef enum logic [2:0] {
    WIN_NONE    = 3'h0,
    WIN_BELOW   = 3'h1,
    WIN_ABOVE   = 3'h2,
    WIN_INSIDE  = 3'h3,
    WIN_OUTSIDE = 3'h4
  } acw_win_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acw_state_type;
  // Controls toward the analog converter
  typedef struct packed {
    logic       sample;
    logic       convert;
    logic [6:0] pos;
    logic [6:0] neg;
  } acw_ana_type;
  // All state of the block
  typedef struct packed {
    acw_state_type state;
    logic [9:0]    cnt;
    logic          start_pend;
    logic          continuous;
    logic [2:0]    win_mode;
    logic [7:0]    samp_len;
    logic [6:0]    pos_w;
    logic [6:0]    neg_w;
    logic          ev_en;
    logic          ev_q;
    logic [1:0]    ien;
    logic [1:0]    flags;
    logic          halt_run;
    logic [7:0]    temp;
    logic [15:0]   result;
    logic [15:0]   low_threshold;
    logic [15:0]   high_threshold;
    acw_ana_type   ana;
    logic          irq;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } acw_regs_type;
endpackage
`default_nettype wire

/* File: verilog/acw_adc_ctrl.sv */
// Purpose: Converter control with window compare, APB register file
// Assumes: Analog core reports completion with a one-cycle done pulse
// Notes:   Converter clock is pclk divided by a fixed factor
`timescale 1ns/10ps
`default_nettype none
module acw_adc_ctrl (
  // APB slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Analog core
  input  wire logic                 adc_done,
  input  wire logic [15:0]          adc_data,
  output acw_pkg::acw_ana_type      ana,
  // System
  input  wire logic                 ev_start,
  input  wire logic                 debug_halted,
  output logic                      irq
);
  acw_pkg::acw_regs_type r;
  acw_pkg::acw_regs_type next_r;
  logic       adv;
  logic       wr_done;
  logic       rd_done;
  logic [5:0] idx;
  logic       wr_stop;

  // Window condition on a finished result
  function automatic logic win_hit(input logic [2:0] m,
                                   input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    unique case (m)
      acw_pkg::WIN_BELOW:   win_hit = v < lo;
      acw_pkg::WIN_ABOVE:   win_hit = v > hi;
      acw_pkg::WIN_INSIDE:  win_hit = (v >= lo) && (v <= hi);
      acw_pkg::WIN_OUTSIDE: win_hit = (v < lo) || (v > hi);
      default:              win_hit = 1'b0; // Off or reserved
    endcase
  endfunction

  // Reserved selector codes fall back to ground
  function automatic logic [6:0] pos_map(input logic [6:0] s);
    if (s <= acw_pkg::POS_PIN_MAX || s == acw_pkg::SEL_GND ||
        s == acw_pkg::POS_THERMAL || s == acw_pkg::POS_SUPPLY ||
        s == acw_pkg::POS_SUPPLY2 ||
        (s >= acw_pkg::SEL_DAC && s <= acw_pkg::POS_REF_LAST)) begin
      pos_map = s;
    end else begin
      pos_map = acw_pkg::SEL_GND;
    end
  endfunction

  function automatic logic [6:0] neg_map(input logic [6:0] s);
    if (s <= acw_pkg::NEG_PIN_MAX || s == acw_pkg::SEL_GND ||
        s == acw_pkg::SEL_DAC) begin
      neg_map = s;
    end else begin
      neg_map = acw_pkg::SEL_GND;
    end
  endfunction

  // Sample phase length in pclk cycles, minus one
  function automatic logic [9:0] samp_load(input logic [7:0] len);
    samp_load = 10'(({2'h0, len} + acw_pkg::SAMPLE_BASE) *
                    acw_pkg::DIV_CYCLES - 10'h001);
  endfunction

  // Bus qualifiers; side effects happen on the completing edge only
  assign adv     = !debug_halted || r.halt_run;
  assign idx     = paddr[7:2];
  assign wr_done = psel && penable && r.pready && pwrite;
  assign rd_done = psel && penable && r.pready && !pwrite;
  assign wr_stop = wr_done && !r.pslverr && idx == acw_pkg::IDX_CMD &&
                   pwdata[acw_pkg::BIT_STOP];

  // Next state of the whole block
  always_comb begin
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.ev_q = ev_start;
    // Answer one cycle into the access phase; data is prepared here
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      unique case (idx)
        acw_pkg::IDX_RUN:
          next_r.prdata[acw_pkg::BIT_CONTINUOUS_MODE] = r.continuous;
        acw_pkg::IDX_WIN:  next_r.prdata[2:0] = r.win_mode;
        acw_pkg::IDX_SAMP: next_r.prdata[7:0] = r.samp_len;
        acw_pkg::IDX_POS:  next_r.prdata[6:0] = r.pos_w;
        acw_pkg::IDX_NEG:  next_r.prdata[6:0] = r.neg_w;
        acw_pkg::IDX_CMD:
          next_r.prdata[acw_pkg::BIT_START] =
            r.start_pend || r.state != acw_pkg::ST_IDLE;
        acw_pkg::IDX_EV:
          next_r.prdata[acw_pkg::BIT_EVEN] = r.ev_en;
        acw_pkg::IDX_IEN:  next_r.prdata[1:0] = r.ien;
        acw_pkg::IDX_IFL:  next_r.prdata[1:0] = r.flags;
        acw_pkg::IDX_HALT:
          next_r.prdata[acw_pkg::BIT_HALTRUN] = r.halt_run;
        acw_pkg::IDX_TMP:  next_r.prdata[7:0] = r.temp;
        acw_pkg::IDX_RESL: next_r.prdata[7:0] = r.result[7:0];
        acw_pkg::IDX_LTL:  next_r.prdata[7:0] = r.low_threshold[7:0];
        acw_pkg::IDX_HTL:  next_r.prdata[7:0] = r.high_threshold[7:0];
        // High bytes come from the latch filled by the low-byte read
        acw_pkg::IDX_RESH, acw_pkg::IDX_LTH, acw_pkg::IDX_HTH:
          next_r.prdata[7:0] = r.temp;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    // Read side effects
    if (rd_done && !r.pslverr) begin
      unique case (idx)
        acw_pkg::IDX_RESL: next_r.temp = r.result[15:8];
        acw_pkg::IDX_LTL:  next_r.temp = r.low_threshold[15:8];
        acw_pkg::IDX_HTL:  next_r.temp = r.high_threshold[15:8];
        default: ;
      endcase
      if (idx == acw_pkg::IDX_RESL || idx == acw_pkg::IDX_RESH) begin
        next_r.flags = 2'h0;
      end
    end
    // Register writes; start and stop are strobes, not storage
    if (wr_done && !r.pslverr) begin
      unique case (idx)
        acw_pkg::IDX_RUN:
          next_r.continuous = pwdata[acw_pkg::BIT_CONTINUOUS_MODE];
        acw_pkg::IDX_WIN:  next_r.win_mode = pwdata[2:0];
        acw_pkg::IDX_SAMP: next_r.samp_len = pwdata[7:0];
        acw_pkg::IDX_POS:  next_r.pos_w = pwdata[6:0];
        acw_pkg::IDX_NEG:  next_r.neg_w = pwdata[6:0];
        acw_pkg::IDX_CMD:
          if (pwdata[acw_pkg::BIT_START]) begin
            next_r.start_pend = 1'b1;
          end
        acw_pkg::IDX_EV:   next_r.ev_en = pwdata[acw_pkg::BIT_EVEN];
        acw_pkg::IDX_IEN:  next_r.ien = pwdata[1:0];
        acw_pkg::IDX_IFL:  next_r.flags = r.flags & ~pwdata[1:0];
        acw_pkg::IDX_HALT: next_r.halt_run = pwdata[acw_pkg::BIT_HALTRUN];
        acw_pkg::IDX_TMP, acw_pkg::IDX_LTL, acw_pkg::IDX_HTL:
          next_r.temp = pwdata[7:0];
        acw_pkg::IDX_LTH:
          next_r.low_threshold = {pwdata[7:0], r.temp};
        acw_pkg::IDX_HTH:
          next_r.high_threshold = {pwdata[7:0], r.temp};
        default: ; // Result is read-only
      endcase
    end
    // Event input launches on its rising edge
    if (r.ev_en && ev_start && !r.ev_q) begin
      next_r.start_pend = 1'b1;
    end
    // Conversion sequencer; halted debug freezes it unless halt_run is set
    unique case (r.state)
      acw_pkg::ST_IDLE:
        if (r.start_pend && adv) begin
          next_r.state = acw_pkg::ST_SAMPLE;
          next_r.cnt = samp_load(r.samp_len);
          next_r.start_pend = 1'b0;
          next_r.ana.pos = pos_map(r.pos_w);
          next_r.ana.neg = neg_map(r.neg_w);
        end
      acw_pkg::ST_SAMPLE:
        if (adv) begin
          if (r.cnt == 10'h000) begin
            next_r.state = acw_pkg::ST_CONVERT;
          end else begin
            next_r.cnt = r.cnt - 10'h001;
          end
        end
      acw_pkg::ST_CONVERT:
        // Done is taken even when frozen, so no result is lost
        if (adc_done) begin
          next_r.result = adc_data;
          next_r.flags[acw_pkg::BIT_RDY] = 1'b1;
          if (win_hit(r.win_mode, adc_data, r.low_threshold,
                      r.high_threshold)) begin
            next_r.flags[acw_pkg::BIT_WIN] = 1'b1;
          end
          if (r.continuous || next_r.start_pend) begin
            next_r.state = acw_pkg::ST_SAMPLE;
            next_r.cnt = samp_load(r.samp_len);
            next_r.start_pend = 1'b0;
            next_r.ana.pos = pos_map(r.pos_w);
            next_r.ana.neg = neg_map(r.neg_w);
          end else begin
            next_r.state = acw_pkg::ST_IDLE;
          end
        end
      default: next_r.state = acw_pkg::ST_IDLE;
    endcase
    // Stop ends everything and beats any start in the same cycle
    if (wr_stop) begin
      next_r.state = acw_pkg::ST_IDLE;
      next_r.start_pend = 1'b0;
      // A cancelled launch must not move the inputs
      next_r.ana.pos = r.ana.pos;
      next_r.ana.neg = r.ana.neg;
    end
    next_r.ana.sample = next_r.state == acw_pkg::ST_SAMPLE;
    next_r.ana.convert = next_r.state == acw_pkg::ST_CONVERT;
    next_r.irq = |(next_r.flags & next_r.ien);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign ana     = r.ana;
  assign irq     = r.irq;

  // Checks
  property p_below_hit;
    @(posedge pclk) disable iff (!presetn)
    (r.state == acw_pkg::ST_CONVERT && adc_done &&
     r.win_mode == acw_pkg::WIN_BELOW && adc_data < r.low_threshold)
    |=> r.flags[acw_pkg::BIT_WIN];
  endproperty
  a_below_hit: assert property (p_below_hit)
    else $error("window below hit not flagged");

  property p_no_hit_when_off;
    @(posedge pclk) disable iff (!presetn)
    $rose(r.flags[acw_pkg::BIT_WIN]) |->
      $past(r.win_mode) != acw_pkg::WIN_NONE && $past(adc_done);
  endproperty
  a_no_hit_when_off: assert property (p_no_hit_when_off)
    else $error("window flag set without a matching completion");

  property p_sample_len;
    @(posedge pclk) disable iff (!presetn)
    (r.state == acw_pkg::ST_IDLE && next_r.state == acw_pkg::ST_SAMPLE)
    |=> r.cnt == 10'(({2'h0, $past(r.samp_len)} + 10'h002) * 10'h002 -
                    10'h001);
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample phase length wrong");

  property p_mux_hold;
    @(posedge pclk) disable iff (!presetn)
    !$stable(r.ana.pos) |-> $past(next_r.state) == acw_pkg::ST_SAMPLE &&
      $past(r.state) != acw_pkg::ST_SAMPLE;
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("input selection changed mid conversion");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    wr_stop |=> r.state == acw_pkg::ST_IDLE && !r.start_pend ##1
      r.state == acw_pkg::ST_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not end the measurement");

  property p_busy_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !r.pready && !pwrite && idx == acw_pkg::IDX_CMD &&
     r.state != acw_pkg::ST_IDLE) |=> r.pready && r.prdata[0];
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("start bit not reading one while busy");

  property p_event;
    @(posedge pclk) disable iff (!presetn)
    (r.ev_en && ev_start && !r.ev_q && r.state == acw_pkg::ST_IDLE &&
     !r.start_pend && !wr_stop) |=> r.start_pend ##1
      (r.state == acw_pkg::ST_SAMPLE || !$past(adv) || $past(wr_stop));
  endproperty
  a_event: assert property (p_event)
    else $error("event edge did not launch a conversion");

  property p_ready_irq;
    @(posedge pclk) disable iff (!presetn)
    (r.state == acw_pkg::ST_CONVERT && adc_done && r.ien[0])
    |=> r.flags[acw_pkg::BIT_RDY] && r.irq;
  endproperty
  a_ready_irq: assert property (p_ready_irq)
    else $error("result ready not flagged or not raised");

  property p_result_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_done && idx == acw_pkg::IDX_RESL && !r.pslverr &&
     !(r.state == acw_pkg::ST_CONVERT && adc_done)) |=> r.flags == 2'h0;
  endproperty
  a_result_clear: assert property (p_result_clear)
    else $error("result read did not clear flags");

  property p_wide_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && idx == acw_pkg::IDX_HTH && !r.pslverr)
    |=> r.high_threshold == {$past(pwdata[7:0]), $past(r.temp)};
  endproperty
  a_wide_write: assert property (p_wide_write)
    else $error("high threshold not committed as a pair");

  property p_halt_freeze;
    @(posedge pclk) disable iff (!presetn)
    (debug_halted && !r.halt_run && r.state == acw_pkg::ST_SAMPLE &&
     !wr_stop) |=> $stable(r.cnt) && r.state == acw_pkg::ST_SAMPLE;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("sampling advanced while halted");

  property p_continuous_mode;
    @(posedge pclk) disable iff (!presetn)
    (r.state == acw_pkg::ST_CONVERT && adc_done && r.continuous &&
     !wr_stop) |=> r.state == acw_pkg::ST_SAMPLE;
  endproperty
  a_continuous_mode: assert property (p_continuous_mode)
    else $error("continuous mode did not restart");
endmodule
`default_nettype wire

/* File: sim/acw_ana_model.sv */
// Purpose: Behavioural analog core facing the converter control block
// Assumes: Convert request is a level held until the done pulse is seen
// Notes:   Data line scrambles every cycle outside the done pulse
`timescale 1ns/10ps
`default_nettype none
module acw_ana_model (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Requests from the control block, settings from the bench
  input  wire acw_pkg::acw_ana_type ana,
  input  wire logic [15:0]          value,
  input  wire logic [3:0]           dly,
  // Answer
  output logic                      adc_done,
  output logic [15:0]               adc_data
);
  logic [3:0] cnt;
  logic       fired;

  // One done pulse per convert level, dly cycles late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 4'h0;
      fired    <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_done <= 1'b0;
      // Stale data must not look valid
      adc_data <= ~adc_data;
      if (!ana.convert) begin
        cnt   <= 4'h0;
        fired <= 1'b0;
      end else if (!fired && cnt == dly) begin
        adc_done <= 1'b1;
        adc_data <= value;
        fired    <= 1'b1;
      end else if (!fired) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/acw_adc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Thresholds set to 0x1000 and 0x2000 before window checks
// Notes:   All waits are bounded; a timeout counts as a mismatch
`timescale 1ns/10ps
`default_nettype none
module acw_adc_ctrl_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite;
  logic                 pready, pslverr, adc_done, irq, ev_start;
  logic                 debug_halted, er;
  logic [7:0]           paddr, rd;
  logic [31:0]          pwdata, prdata;
  logic [15:0]          adc_data, value;
  logic [3:0]           dly;
  acw_pkg::acw_ana_type ana;
  int                   fails, n_tests;

  acw_adc_ctrl acw_adc_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_done(adc_done), .adc_data(adc_data), .ana(ana),
    .ev_start(ev_start), .debug_halted(debug_halted), .irq(irq));
  acw_ana_model acw_ana_model_inst (.pclk(pclk), .presetn(presetn),
    .ana(ana), .value(value), .dly(dly), .adc_done(adc_done),
    .adc_data(adc_data));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic conclude();
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; an idle edge follows so psel is never re-raised early
  task automatic apb(input logic w, input logic [5:0] ix,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready wait", 16'h0001, 16'h0000);
      conclude();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [5:0] ix,
                     input logic [7:0] exp);
    apb(1'b0, ix, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic w_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (irq !== 1'b1) begin
      chk("irq wait", 16'h0001, 16'h0000);
      conclude();
    end
  endtask

  task automatic w_samp();
    int n;
    n = 0;
    while (ana.sample !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (ana.sample !== 1'b1) begin
      chk("sample wait", 16'h0001, 16'h0000);
      conclude();
    end
  endtask

  // Expected window hit for thresholds 0x1000 and 0x2000
  function automatic logic hit(input logic [2:0] m, input logic [15:0] v);
    case (m)
      3'h1: return v < 16'h1000;
      3'h2: return v > 16'h2000;
      3'h3: return v >= 16'h1000 && v <= 16'h2000;
      3'h4: return v < 16'h1000 || v > 16'h2000;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_reset();
    logic [5:0] ix [8] = '{acw_pkg::IDX_SAMP, acw_pkg::IDX_POS,
      acw_pkg::IDX_CMD, acw_pkg::IDX_IEN, acw_pkg::IDX_IFL,
      acw_pkg::IDX_TMP, acw_pkg::IDX_RESH, acw_pkg::IDX_HTL};
    for (int i = 0; i < 8; i++) rdc("reset value", ix[i], 8'h00);
    apb(1'b1, 6'h01, 8'hff);
    chk("unmapped error", 16'h0001, {15'h0000, er});
    rdc("unmapped read", 6'h01, 8'h00);
  endtask

  task automatic t_thr();
    apb(1'b1, acw_pkg::IDX_LTL, 8'h00);
    apb(1'b1, acw_pkg::IDX_LTH, 8'h10);
    apb(1'b1, acw_pkg::IDX_HTL, 8'h00);
    apb(1'b1, acw_pkg::IDX_HTH, 8'h20);
    rdc("low thr low", acw_pkg::IDX_LTL, 8'h00);
    rdc("temp latched", acw_pkg::IDX_TMP, 8'h10);
    rdc("low thr high", acw_pkg::IDX_LTH, 8'h10);
    rdc("high thr low", acw_pkg::IDX_HTL, 8'h00);
    rdc("high thr high", acw_pkg::IDX_HTH, 8'h20);
    apb(1'b1, acw_pkg::IDX_TMP, 8'h5a);
    rdc("temp rw", acw_pkg::IDX_TMP, 8'h5a);
  endtask

  // Sample length, selectors, deferred selector change, busy bit
  task automatic t_sample();
    int n;
    n = 0;
    dly <= 4'hc;
    apb(1'b1, acw_pkg::IDX_SAMP, 8'h03);
    apb(1'b1, acw_pkg::IDX_POS, 8'h15);
    apb(1'b1, acw_pkg::IDX_NEG, 8'h48);
    apb(1'b1, acw_pkg::IDX_IEN, 8'h03);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_samp();
    while (ana.sample === 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    chk("sample cycles", 16'h000a, n[15:0]);
    chk("pos applied", 16'h0015, {9'h000, ana.pos});
    chk("neg applied", 16'h0048, {9'h000, ana.neg});
    apb(1'b1, acw_pkg::IDX_POS, 8'h42);
    chk("pos held", 16'h0015, {9'h000, ana.pos});
    rdc("busy", acw_pkg::IDX_CMD, 8'h01);
    w_irq();
    rdc("busy cleared", acw_pkg::IDX_CMD, 8'h00);
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_samp();
    chk("pos next", 16'h0042, {9'h000, ana.pos});
    // Start during a conversion queues exactly one more
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_irq();
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    rdc("queued start", acw_pkg::IDX_CMD, 8'h01);
    w_irq();
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    apb(1'b1, acw_pkg::IDX_SAMP, 8'h00);
    dly <= 4'h2;
  endtask

  task automatic t_stop();
    // Reserved selector codes must reach the core as ground
    apb(1'b1, acw_pkg::IDX_POS, 8'h16);
    apb(1'b1, acw_pkg::IDX_NEG, 8'h10);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_samp();
    chk("pos reserved", 16'h0040, {9'h000, ana.pos});
    chk("neg reserved", 16'h0040, {9'h000, ana.neg});
    apb(1'b1, acw_pkg::IDX_CMD, 8'h03);
    chk("stopped", 16'h0000, {14'h0000, ana.sample, ana.convert});
    repeat (40) @(posedge pclk);
    rdc("no flags", acw_pkg::IDX_IFL, 8'h00);
    rdc("start dropped", acw_pkg::IDX_CMD, 8'h00);
  endtask

  task automatic t_mask();
    apb(1'b1, acw_pkg::IDX_IEN, 8'h02);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    repeat (40) @(posedge pclk);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    rdc("ready only", acw_pkg::IDX_IFL, 8'h01);
    apb(1'b1, acw_pkg::IDX_IEN, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq enabled", 16'h0001, {15'h0000, irq});
    apb(1'b1, acw_pkg::IDX_IFL, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    apb(1'b1, acw_pkg::IDX_IEN, 8'h03);
  endtask

  task automatic t_event();
    apb(1'b1, acw_pkg::IDX_EV, 8'h01);
    ev_start <= 1'b1;
    w_irq();
    rdc("event result", acw_pkg::IDX_IFL, 8'h01);
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    ev_start <= 1'b0;
    apb(1'b1, acw_pkg::IDX_EV, 8'h00);
    ev_start <= 1'b1;
    repeat (60) @(posedge pclk);
    rdc("event off", acw_pkg::IDX_IFL, 8'h00);
    ev_start <= 1'b0;
  endtask

  task automatic t_halt();
    debug_halted <= 1'b1;
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    repeat (30) @(posedge pclk);
    chk("frozen", 16'h0000, {15'h0000, ana.sample});
    apb(1'b1, acw_pkg::IDX_HALT, 8'h01);
    w_irq();
    rdc("run in halt", acw_pkg::IDX_IFL, 8'h01);
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    // Halt taken mid-sample must freeze the count
    apb(1'b1, acw_pkg::IDX_SAMP, 8'h10);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_samp();
    apb(1'b1, acw_pkg::IDX_HALT, 8'h00);
    repeat (60) @(posedge pclk);
    chk("frozen in sample", 16'h0001, {15'h0000, ana.sample});
    debug_halted <= 1'b0;
    w_irq();
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    apb(1'b1, acw_pkg::IDX_SAMP, 8'h00);
  endtask

  task automatic t_free();
    apb(1'b1, acw_pkg::IDX_RUN, 8'h02);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
    w_irq();
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
    w_irq();
    rdc("free second", acw_pkg::IDX_IFL, 8'h01);
    apb(1'b1, acw_pkg::IDX_CMD, 8'h02);
    apb(1'b1, acw_pkg::IDX_RUN, 8'h00);
    apb(1'b1, acw_pkg::IDX_IFL, 8'h03);
  endtask

  // All modes plus reserved code 5, on and beside both thresholds
  task automatic t_window();
    logic [15:0] v [4] = '{16'h0fff, 16'h1000, 16'h2000, 16'h2001};
    logic [7:0]  f;
    for (int m = 0; m < 6; m++) begin
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, acw_pkg::IDX_WIN, m[7:0]);
        value <= v[i];
        apb(1'b1, acw_pkg::IDX_CMD, 8'h01);
        w_irq();
        f = {6'h00, hit(m[2:0], v[i]), 1'b1};
        rdc("flags", acw_pkg::IDX_IFL, f);
        apb(1'b1, acw_pkg::IDX_IFL, 8'h00);
        rdc("flags kept", acw_pkg::IDX_IFL, f);
        rdc("result low", acw_pkg::IDX_RESL, v[i][7:0]);
        rdc("result high", acw_pkg::IDX_RESH, v[i][15:8]);
        rdc("flags read clear", acw_pkg::IDX_IFL, 8'h00);
      end
    end
  endtask

  // Main sequence
  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h00000000;
    ev_start     = 1'b0;
    debug_halted = 1'b0;
    value        = 16'h0000;
    dly          = 4'h2;
    fails        = 0;
    n_tests      = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_thr();
    t_sample();
    t_stop();
    t_mask();
    t_event();
    t_halt();
    t_free();
    t_window();
    conclude();
  end
endmodule
`default_nettype wire
